// ===== hw/alarm_map.svh
// Offsets, field positions, defaults and counts for the chassis alarm block
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH

// Register offsets (byte addresses, one 32-bit word each)
`define REG_FAN_MIN 8'h00
`define REG_TEMP_MAX 8'h04
`define REG_R33_HI 8'h08
`define REG_R33_LO 8'h0c
`define REG_R5_HI 8'h10
`define REG_R5_LO 8'h14
`define REG_R12_HI 8'h18
`define REG_R12_LO 8'h1c
`define REG_RN12_HI 8'h20
`define REG_RN12_LO 8'h24
`define REG_SB_HI 8'h28
`define REG_SB_LO 8'h2c
`define REG_LATCH 8'h30
`define REG_CLEAR 8'h34
`define REG_CONTROL 8'h38
`define REG_ENABLE_BASE 8'h40
`define REG_OCCURRED_BASE 8'h50

// Control register fields
`define CTL_GLOBAL_CLEAR 0
`define CTL_CHASSIS_RESET 1

// Channel indices
`define CH_FAN 0
`define CH_TEMP 1
`define CH_R33 2
`define CH_R5 3
`define CH_R12 4
`define CH_RN12 5
`define CH_SB 6
`define CH_REFCLK 7

// Sizes
`define NUM_FANS 4
`define NUM_TEMPS 8
`define NUM_TEMPS_SMALL 5
`define NUM_CONSUMERS 4

// Defaults: RPM, degrees C, rail limits in millivolts (signed)
`define FAN_MIN_DEF 16'd1200
`define FAN_MIN_DEF_SMALL 16'd900
`define FAN_MIN_LO 16'd1
`define FAN_MIN_HI 16'd10000
`define TEMP_MAX_DEF 16'd70
`define TEMP_MAX_LO 16'd1
`define TEMP_MAX_HI 16'd70
`define R33_NOM 16'sd3300
`define R33_HI_DEF 16'sd3630
`define R33_LO_DEF 16'sd2970
`define R5_NOM 16'sd5000
`define R5_HI_DEF 16'sd5250
`define R5_LO_DEF 16'sd4750
`define R12_NOM 16'sd12000
`define R12_HI_DEF 16'sd12600
`define R12_LO_DEF 16'sd11400
`define RN12_NOM -16'sd12000
`define RN12_HI_DEF -16'sd11400
`define RN12_LO_DEF -16'sd12600
`define SB_NOM 16'sd5000
`define SB_HI_DEF 16'sd5250
`define SB_LO_DEF 16'sd4750

`endif

// ===== hw/alarm_pkg.sv
// Types shared by the chassis alarm block
package alarm_pkg;
   typedef logic [15:0] word16_t;
   typedef logic signed [15:0] mv_t;
   typedef logic [7:0] chan_mask_t;
endpackage

// ===== hw/chassis_alarm_latch_monitor.sv
// Chassis alarm latches, shared thresholds and per-consumer indications
// Summary of operation
// - Eight channels: fan, temperature, four main rails, standby rail, ref clock.
// - Each channel has one latch, set while its condition is violated.
// - Fan violation when any fan reads below the minimum speed.
// - Rail violation when voltage lies outside its lower/upper window.
// - Latches have no reset value; a present violation reads set at once.
// - Per-channel clear resets only that channel's latch.
// - Global clear resets all eight latches together.
// - Set overrides clear; a standing violation re-sets the latch.
// - Occurred is latch AND that consumer's enable.
// - Dropping enable forces occurred false, latch untouched.
// - Threshold writes never clear a set latch.
// - One shared threshold store; the last write from anyone wins.
// - Each consumer has own enables and indications over shared latches.
// - Thresholds return to defaults on every power cycle.
// - Fan minimum defaults 1200 or 900 RPM, settable 1 to 10000.
// - Temperature maximum defaults 70 C, settable 1 to 70.
// - Rail limits default to the tabulated upper and lower values.
// - Rail limits settable 0.01% to 20% beyond nominal.
// - Eight temperature sensors, five on small chassis; any one over trips.
// - Host chassis reset restores all default thresholds.
//
// Added by the designer: the register offsets and strobed register access.
`include "alarm_map.svh"
module chassis_alarm_latch_monitor
   import alarm_pkg::*;
(
   // Clock and power-cycle reset
   input wire logic clock,
   input wire logic reset,
   // Variant strap: small chassis
   input wire logic small_chassis,
   // Sensors, asynchronous to clock
   input wire logic [`NUM_FANS*16-1:0] fan_rpm,
   input wire logic [`NUM_TEMPS*16-1:0] temp_c,
   input wire logic [15:0] rail_33_mv,
   input wire logic [15:0] rail_5_mv,
   input wire logic [15:0] rail_12_mv,
   input wire logic [15:0] rail_n12_mv,
   input wire logic [15:0] standby_rail_mv,
   input wire logic ref_source_sel,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Alarm status
   output logic [7:0] alarm_latch,
   output logic [`NUM_CONSUMERS*8-1:0] alarm_occurred
);

   // Sensor synchronisers; multi-bit words are slow-moving readings
   logic [`NUM_FANS*16-1:0] fan_s1_q, fan_s2_q;
   logic [`NUM_TEMPS*16-1:0] temp_s1_q, temp_s2_q;
   logic [79:0] rail_s1_q, rail_s2_q;
   logic ref_s1_q, ref_s2_q, ref_s3_q;

   always_ff @(posedge clock) begin
      fan_s1_q <= fan_rpm;
      fan_s2_q <= fan_s1_q;
      temp_s1_q <= temp_c;
      temp_s2_q <= temp_s1_q;
      rail_s1_q <= {standby_rail_mv, rail_n12_mv, rail_12_mv, rail_5_mv,
                    rail_33_mv};
      rail_s2_q <= rail_s1_q;
      ref_s1_q <= ref_source_sel;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
   end

   // Strap caught on the first edge after reset release
   logic small_q, strap_done_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         small_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         small_q <= small_chassis;
         strap_done_q <= 1'b1;
      end
   end

   // Threshold store
   word16_t fan_min_q, temp_max_q;
   mv_t hi_q [5];
   mv_t lo_q [5];
   logic [`NUM_CONSUMERS*8-1:0] enable_q;
   logic global_clear, chassis_reset;
   chan_mask_t chan_clear;

   function automatic logic in_u(input word16_t v, input word16_t lo,
                                 input word16_t hi);
      in_u = (v >= lo) && (v <= hi);
   endfunction

   // Limit window: nom+0.01% .. nom+20% (or below), magnitude based
   function automatic logic rail_ok(input mv_t v, input mv_t nom,
                                    input logic upper);
      logic signed [31:0] a, n, lo, hi;
      a = (v < 0) ? -32'(v) : 32'(v);
      n = (nom < 0) ? -32'(nom) : 32'(nom);
      if (upper ^ (nom < 0)) begin
         lo = n + (n + 32'sd9999) / 32'sd10000;
         hi = n + n / 32'sd5;
      end else begin
         lo = n - n / 32'sd5;
         hi = n - (n + 32'sd9999) / 32'sd10000;
      end
      rail_ok = ((v < 0) == (nom < 0)) && (a >= lo) && (a <= hi);
   endfunction

   function automatic mv_t nom_of(input int i);
      case (i)
         0: nom_of = `R33_NOM;
         1: nom_of = `R5_NOM;
         2: nom_of = `R12_NOM;
         3: nom_of = `RN12_NOM;
         default: nom_of = `SB_NOM;
      endcase
   endfunction

   function automatic logic [7:0] hi_off(input int i);
      hi_off = 8'(`REG_R33_HI + 8 * i);
   endfunction

   assign chassis_reset = reg_write && (reg_addr == `REG_CONTROL) &&
                          reg_wdata[`CTL_CHASSIS_RESET];

   // Power cycle and host chassis reset both restore defaults
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         fan_min_q <= `FAN_MIN_DEF;
         temp_max_q <= `TEMP_MAX_DEF;
         hi_q[0] <= `R33_HI_DEF;
         lo_q[0] <= `R33_LO_DEF;
         hi_q[1] <= `R5_HI_DEF;
         lo_q[1] <= `R5_LO_DEF;
         hi_q[2] <= `R12_HI_DEF;
         lo_q[2] <= `R12_LO_DEF;
         hi_q[3] <= `RN12_HI_DEF;
         lo_q[3] <= `RN12_LO_DEF;
         hi_q[4] <= `SB_HI_DEF;
         lo_q[4] <= `SB_LO_DEF;
      end else if (chassis_reset || (!strap_done_q)) begin
         fan_min_q <= (strap_done_q ? small_q : small_chassis) ?
                      `FAN_MIN_DEF_SMALL : `FAN_MIN_DEF;
         temp_max_q <= `TEMP_MAX_DEF;
         hi_q[0] <= `R33_HI_DEF;
         lo_q[0] <= `R33_LO_DEF;
         hi_q[1] <= `R5_HI_DEF;
         lo_q[1] <= `R5_LO_DEF;
         hi_q[2] <= `R12_HI_DEF;
         lo_q[2] <= `R12_LO_DEF;
         hi_q[3] <= `RN12_HI_DEF;
         lo_q[3] <= `RN12_LO_DEF;
         hi_q[4] <= `SB_HI_DEF;
         lo_q[4] <= `SB_LO_DEF;
      end else if (reg_write) begin
         // Out-of-range writes are ignored, keeping the old value
         if (reg_addr == `REG_FAN_MIN) begin
            if (in_u(reg_wdata[15:0], `FAN_MIN_LO, `FAN_MIN_HI))
               fan_min_q <= reg_wdata[15:0];
         end else if (reg_addr == `REG_TEMP_MAX) begin
            if (in_u(reg_wdata[15:0], `TEMP_MAX_LO, `TEMP_MAX_HI))
               temp_max_q <= reg_wdata[15:0];
         end else begin
            for (int i = 0; i < 5; i++) begin
               if (reg_addr == hi_off(i) &&
                   rail_ok(mv_t'(reg_wdata[15:0]), nom_of(i), 1'b1))
                  hi_q[i] <= mv_t'(reg_wdata[15:0]);
               if (reg_addr == 8'(hi_off(i) + 8'h04) &&
                   rail_ok(mv_t'(reg_wdata[15:0]), nom_of(i), 1'b0))
                  lo_q[i] <= mv_t'(reg_wdata[15:0]);
            end
         end
      end
   end

   // Per-consumer enables
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         enable_q <= '0;
      end else if (reg_write) begin
         for (int c = 0; c < `NUM_CONSUMERS; c++) begin
            if (reg_addr == 8'(`REG_ENABLE_BASE + 4 * c))
               enable_q[c*8 +: 8] <= reg_wdata[7:0];
         end
      end
   end

   // Violation conditions
   chan_mask_t violate;
   always_comb begin
      violate = '0;
      for (int f = 0; f < `NUM_FANS; f++) begin
         if (fan_s2_q[f*16 +: 16] < fan_min_q)
            violate[`CH_FAN] = 1'b1;
      end
      for (int t = 0; t < `NUM_TEMPS; t++) begin
         if ((t < `NUM_TEMPS_SMALL || !small_q) &&
             temp_s2_q[t*16 +: 16] > temp_max_q)
            violate[`CH_TEMP] = 1'b1;
      end
      for (int r = 0; r < 5; r++) begin
         if (mv_t'(rail_s2_q[r*16 +: 16]) < lo_q[r] ||
             mv_t'(rail_s2_q[r*16 +: 16]) > hi_q[r])
            violate[`CH_R33 + r] = 1'b1;
      end
      violate[`CH_REFCLK] = ref_s2_q ^ ref_s3_q;
   end

   // Clear requests
   assign global_clear = reg_write && (reg_addr == `REG_CONTROL) &&
                         reg_wdata[`CTL_GLOBAL_CLEAR];
   assign chan_clear = (reg_write && (reg_addr == `REG_CLEAR)) ?
                       reg_wdata[7:0] : 8'h00;

   // Alarm latches: no reset term, so power-on value follows the set input
   chan_mask_t latch_q;
   always_ff @(posedge clock) begin
      for (int k = 0; k < 8; k++) begin
         if (violate[k])
            latch_q[k] <= 1'b1;
         else if (global_clear || chan_clear[k])
            latch_q[k] <= 1'b0;
         // Threshold writes have no path here
      end
   end
   // Seen without the register stage so a standing violation reads set
   assign alarm_latch = latch_q | violate;

   always_comb begin
      for (int c = 0; c < `NUM_CONSUMERS; c++)
         alarm_occurred[c*8 +: 8] = alarm_latch & enable_q[c*8 +: 8];
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         reg_rdata <= '0;
         if (reg_addr == `REG_FAN_MIN)
            reg_rdata <= {16'h0000, fan_min_q};
         else if (reg_addr == `REG_TEMP_MAX)
            reg_rdata <= {16'h0000, temp_max_q};
         else if (reg_addr == `REG_LATCH)
            reg_rdata <= {24'h000000, alarm_latch};
         else if (reg_addr == `REG_CONTROL)
            reg_rdata <= {31'h00000000, small_q};
         else begin
            for (int i = 0; i < 5; i++) begin
               if (reg_addr == hi_off(i))
                  reg_rdata <= {{16{hi_q[i][15]}}, hi_q[i]};
               if (reg_addr == 8'(hi_off(i) + 8'h04))
                  reg_rdata <= {{16{lo_q[i][15]}}, lo_q[i]};
            end
            for (int c = 0; c < `NUM_CONSUMERS; c++) begin
               if (reg_addr == 8'(`REG_ENABLE_BASE + 4 * c))
                  reg_rdata <= {24'h000000, enable_q[c*8 +: 8]};
               if (reg_addr == 8'(`REG_OCCURRED_BASE + 4 * c))
                  reg_rdata <= {24'h000000, alarm_occurred[c*8 +: 8]};
            end
         end
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

// ===== tb/alarm_props.sv
// Port checker for the chassis alarm block
`include "alarm_map.svh"
module alarm_props
   import alarm_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // Alarm status
   input wire logic [7:0] alarm_latch,
   input wire logic [`NUM_CONSUMERS*8-1:0] alarm_occurred
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [`NUM_CONSUMERS*8-1:0] en_q;
   logic [1:0] ok_q;
   logic [7:0] clr;
   // Latches hold X until a global clear, so the latch-keep check waits for one
   assign clr = (reg_write && reg_addr == `REG_CLEAR) ? reg_wdata[7:0] :
      (reg_write && reg_addr == `REG_CONTROL &&
       reg_wdata[`CTL_GLOBAL_CLEAR]) ?
      8'hff : 8'h00;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         en_q <= '0;
         ok_q <= 2'b00;
      end else begin
         ok_q <= {ok_q[0], ok_q[0] | (clr == 8'hff)};
         for (int c = 0; c < `NUM_CONSUMERS; c++) begin
            if (reg_write && reg_addr == `REG_ENABLE_BASE + 8'(4 * c))
               en_q[8*c+:8] <= reg_wdata[7:0];
         end
      end
   end
   sequence s_rd_temp;
      reg_read && reg_addr == `REG_TEMP_MAX;
   endsequence
   sequence s_wr_temp;
      reg_write && reg_addr == `REG_TEMP_MAX && reg_wdata[15:0] >= 16'd1
         && reg_wdata[15:0] <= 16'd70;
   endsequence
   a_occ_mask: assert property (
      alarm_occurred == ({`NUM_CONSUMERS{alarm_latch}} & en_q))
      else $error("occurred differs from latch and enable");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside read answer");
   a_latch_keep: assert property (ok_q[1] |->
      ($past(alarm_latch) & ~alarm_latch & ~$past(clr)) == 8'h00)
      else $error("latch fell without a clear");
   a_rd_latch: assert property (reg_read && reg_addr == `REG_LATCH |=>
      reg_rdata[7:0] == $past(alarm_latch))
      else $error("latch read mismatch");
   a_rd_occ: assert property (reg_read &&
      reg_addr == `REG_OCCURRED_BASE + 8'h04
      |=> reg_rdata[7:0] == $past(alarm_occurred[15:8]))
      else $error("occurred read mismatch");
   a_rd_unmapped: assert property (reg_read && reg_addr == 8'h3c |=>
      reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_temp_last: assert property (s_wr_temp ##1 s_rd_temp |=>
      reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
      else $error("last threshold write not in effect");
   a_temp_range: assert property (reg_write && reg_addr == `REG_TEMP_MAX
      && reg_wdata[15:0] > 16'd70 ##1 s_rd_temp |=>
      reg_rdata[15:0] >= 16'd1 && reg_rdata[15:0] <= 16'd70)
      else $error("temperature threshold out of range");
endmodule
bind chassis_alarm_latch_monitor alarm_props u_props (.clock, .reset,
   .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .alarm_latch,
   .alarm_occurred);

// ===== tb/sensor_model.sv
// Sensor side: fans, temperature sensors, rails, reference select
`include "alarm_map.svh"
module sensor_model
   import alarm_pkg::*;
(
   // Clock and fault choice, one bit a channel
   input wire logic clock,
   input wire logic [7:0] fault,
   // Readings
   output logic [`NUM_FANS*16-1:0] fan_rpm,
   output logic [`NUM_TEMPS*16-1:0] temp_c,
   output logic [15:0] rail_33_mv,
   output logic [15:0] rail_5_mv,
   output logic [15:0] rail_12_mv,
   output logic [15:0] rail_n12_mv,
   output logic [15:0] standby_rail_mv,
   output logic ref_source_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_q = 1'b0;
   logic f7_q = 1'b0;
   // Sensor 4 exists on both variants, so it carries the hot reading
   always_comb begin
      fan_rpm = {`NUM_FANS{16'd3000}};
      temp_c = {`NUM_TEMPS{16'd25}};
      if (fault[0]) fan_rpm[47:32] = 16'd500;
      if (fault[1]) temp_c[79:64] = 16'd90;
   end
   assign rail_33_mv = fault[2] ? 16'd2900 : 16'd3300;
   assign rail_5_mv = fault[3] ? 16'd5300 : 16'd5000;
   assign rail_12_mv = fault[4] ? 16'd12700 : 16'd12000;
   assign rail_n12_mv = fault[5] ? -16'sd12700 : -16'sd12000;
   assign standby_rail_mv = fault[6] ? 16'd4700 : 16'd5000;
   always_ff @(posedge clock) begin
      f7_q <= fault[7];
      if (fault[7] && !f7_q) ref_q <= ~ref_q;
   end
   assign ref_source_sel = ref_q;
endmodule

// ===== tb/chassis_alarm_latch_monitor_tb.sv
// Testbench for the chassis alarm block
`include "alarm_map.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module chassis_alarm_latch_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import alarm_pkg::*;
   logic clock = 0, reset = 1, small_chassis = 0, ref_source_sel;
   logic reg_write = 0, reg_read = 0;
   logic [7:0] reg_addr = 0, fault = 0, alarm_latch;
   logic [31:0] reg_wdata = 0, reg_rdata, alarm_occurred, d;
   logic [63:0] fan_rpm;
   logic [127:0] temp_c;
   logic [15:0] rail_33_mv, rail_5_mv, rail_12_mv, rail_n12_mv;
   logic [15:0] standby_rail_mv;
   int miscompares = 0, compares = 0;
   int dv[12] = '{1200, 70, 3630, 2970, 5250, 4750, 12600, 11400, -11400,
      -12600, 5250, 4750};
   always #4 clock = ~clock;
   sensor_model PM (.clock, .fault, .fan_rpm, .temp_c, .rail_33_mv,
      .rail_5_mv, .rail_12_mv, .rail_n12_mv, .standby_rail_mv,
      .ref_source_sel);
   chassis_alarm_latch_monitor DUT (.clock, .reset, .small_chassis,
      .fan_rpm, .temp_c, .rail_33_mv, .rail_5_mv, .rail_12_mv, .rail_n12_mv,
      .standby_rail_mv, .ref_source_sel, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .alarm_latch, .alarm_occurred);
   task idle(int n);
      repeat (n) begin
         @(posedge clock);
         reg_write <= 0;
         reg_read <= 0;
      end
      #1;
   endtask
   // Strobe stays up on return so writes can run back to back
   task wr(logic [7:0] a, logic [31:0] v);
      @(posedge clock);
      reg_write <= 1;
      reg_read <= 0;
      reg_addr <= a;
      reg_wdata <= v;
   endtask
   task rd(logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_read <= 1;
      reg_write <= 0;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 0;
      #1 v = reg_rdata;
   endtask
   task setf(logic [7:0] f);
      @(posedge clock);
      fault <= f;
      idle(5);
   endtask
   task do_reset(logic s);
      @(posedge clock);
      reset <= 1;
      small_chassis <= s;
      repeat (5) @(posedge clock);
      reset <= 0;
      idle(6);
   endtask
   task t_defaults(int fan);
      for (int i = 0; i < 12; i++) begin
         rd(8'(4 * i), d);
         `CHK("threshold", 32'(i == 0 ? fan : dv[i]), d)
      end
      rd(`REG_CONTROL, d);
      `CHK("strap", fan == 900, d[0])
      $display("defaults done");
   endtask
   task t_channels();
      wr(`REG_CONTROL, 1);
      idle(2);
      `CHK("gclear", 8'h00, alarm_latch)
      for (int i = 0; i < 8; i++) begin
         setf(8'h01 << i);
         setf(0);
         `CHK("latch", 8'h01 << i, alarm_latch)
         wr(`REG_CLEAR, 8'h01 << i);
         idle(2);
         `CHK("chclear", 8'h00, alarm_latch)
      end
      setf(8'h03);
      wr(`REG_CLEAR, 1);
      idle(2);
      `CHK("setwins", 8'h03, alarm_latch)
      setf(0);
      wr(`REG_CLEAR, 1);
      idle(2);
      `CHK("onlyone", 8'h02, alarm_latch)
      wr(`REG_CONTROL, 1);
      idle(2);
      `CHK("allclear", 8'h00, alarm_latch)
      $display("channels done");
   endtask
   task t_occ();
      setf(8'h05);
      setf(0);
      wr(`REG_ENABLE_BASE + 8'h04, 8'h04);
      wr(`REG_ENABLE_BASE + 8'h08, 8'hff);
      idle(2);
      `CHK("occurred", 32'h00050400, alarm_occurred)
      rd(`REG_OCCURRED_BASE + 8'h04, d);
      `CHK("occ_read", 32'h4, d)
      wr(`REG_ENABLE_BASE + 8'h08, 0);
      idle(2);
      `CHK("disabled", 32'h00000400, alarm_occurred)
      `CHK("kept", 8'h05, alarm_latch)
      rd(`REG_LATCH, d);
      `CHK("latch_read", 32'h5, d)
      wr(`REG_CLEAR, 8'h04);
      idle(2);
      `CHK("shared", 32'h0, alarm_occurred)
      rd(8'h3c, d);
      `CHK("unmapped", 32'h0, d)
      wr(`REG_CONTROL, 1);
      $display("occurred done");
   endtask
   task t_thresh();
      wr(`REG_TEMP_MAX, 20);
      rd(`REG_TEMP_MAX, d);
      `CHK("temp_wr", 32'd20, d)
      wr(`REG_TEMP_MAX, 71);
      rd(`REG_TEMP_MAX, d);
      `CHK("temp_rng", 32'd20, d)
      wr(`REG_TEMP_MAX, 70);
      idle(3);
      `CHK("stays", 1'b1, alarm_latch[1])
      wr(`REG_CLEAR, 2);
      idle(2);
      `CHK("cleared", 8'h00, alarm_latch)
      wr(`REG_FAN_MIN, 0);
      rd(`REG_FAN_MIN, d);
      `CHK("fan_lo", 32'd1200, d)
      wr(`REG_FAN_MIN, 10000);
      rd(`REG_FAN_MIN, d);
      `CHK("fan_hi", 32'd10000, d)
      wr(`REG_R33_HI, 3961);
      wr(`REG_R33_LO, 2639);
      rd(`REG_R33_HI, d);
      `CHK("r33_hi", 32'd3630, d)
      rd(`REG_R33_LO, d);
      `CHK("r33_lo", 32'd2970, d)
      wr(`REG_R5_HI, 5500);
      wr(`REG_R5_LO, 4500);
      rd(`REG_R5_HI, d);
      `CHK("r5_hi", 32'd5500, d)
      rd(`REG_R5_LO, d);
      `CHK("r5_lo", 32'd4500, d)
      wr(`REG_CONTROL, 2);
      idle(2);
      t_defaults(1200);
      $display("thresholds done");
   endtask
   task wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100us;
      miscompares++;
      wrap_up();
   end
   initial begin
      do_reset(0);
      t_defaults(1200);
      t_channels();
      t_occ();
      t_thresh();
      setf(8'h04);
      do_reset(1);
      `CHK("poweron", 1'b1, alarm_latch[2])
      t_defaults(900);
      wrap_up();
   end
endmodule
